// file: logic/rof_result_switch_consts.svh
// timing and field constants for the result output and function switch block
`ifndef ROF_RESULT_SWITCH_CONSTS_SVH
`define ROF_RESULT_SWITCH_CONSTS_SVH

// ==========================================================
// clock and times
`define ROF_CLK_HZ          20_000_000
`define ROF_HZ_PER_KHZ      1000
`define ROF_SWREQ_MIN_MS    1
`define ROF_STROBE_MIN_MS   8'h01

// ==========================================================
// function codes and value limits
`define ROF_FN_PROC_MEM     4'h0
`define ROF_FN_PROC_CARD    4'h1
`define ROF_FN_WINDOW       4'h2
`define ROF_FN_SHUTTER      4'h3
`define ROF_FN_GAIN         4'h4
`define ROF_FN_BRIGHT       4'h5
`define ROF_FN_CAPTURE      4'h6
`define ROF_PROC_MAX        8'h1F
`define ROF_WINDOW_MAX      8'h7F
`define ROF_SHUTTER_MAX     4'h9
`define ROF_LEVEL_MAX       7'h64
`define ROF_CAM_BIT         7

// ==========================================================
// 16-bit range limits
`define ROF_S16_MAX         32'sh0000_7FFF
`define ROF_S16_MIN         -32'sh0000_8000
`define ROF_U16_MAX         32'sh0000_FFFF

`endif

// file: logic/rof_pkg.sv
// types shared by the result output and function switch block
package rof_pkg;

	typedef enum logic [1:0] {
		OE_IDLE,
		OE_DELAY,
		OE_STROBE
	} rof_out_state_e;

	typedef enum logic {
		SW_IDLE,
		SW_BUSY
	} rof_sw_state_e;

	typedef struct packed {
		logic [3:0] code;
		logic [6:0] value;
		logic       camera;
	} rof_switch_cmd_s;

	typedef struct packed {
		logic        fmt_32bit;
		logic        signed_16;
		logic [7:0]  strobe_delay_ms;
		logic [7:0]  strobe_len_ms;
	} rof_out_cfg_s;

endpackage : rof_pkg

// file: logic/rof_result_switch.sv
// result output sequencing, image save buffer and function switch decoding
`timescale 1ns/1ns
`include "rof_result_switch_consts.svh"

module rof_result_switch #(
	parameter int CYC_PER_MS = `ROF_CLK_HZ / `ROF_HZ_PER_KHZ
) (
	input  wire logic                   clk_sys,
	input  wire logic                   resetn,
	input  wire rof_pkg::rof_out_cfg_s  out_cfg,
	input  wire logic                   cycle_start,
	input  wire logic                   cycle_done,
	input  wire logic [31:0]            result_in,
	input  wire logic                   save_enable,
	input  wire logic                   save_discard_mode,
	input  wire logic                   save_done,
	input  wire logic [3:0]             func_select_lines,
	input  wire logic [7:0]             value_in_lines,
	input  wire logic                   switch_request,
	input  wire logic                   switch_enable,
	input  wire logic                   switch_done,
	output logic                        ready,
	output logic                        send_start,
	output logic [15:0]                 result_out_lines,
	output logic                        result_strobe,
	output logic                        save_start,
	output logic                        image_dropped,
	output logic                        save_busy,
	output logic                        save_buf_full,
	output logic                        switch_ready,
	output logic                        switch_ok_flag,
	output logic                        switch_fail_flag,
	output rof_pkg::rof_switch_cmd_s    switch_cmd,
	output logic                        switch_cmd_valid
);
	localparam int SWREQ_CYC = `ROF_SWREQ_MIN_MS * CYC_PER_MS + 1;
	if (CYC_PER_MS < 2 || SWREQ_CYC > 65535) begin : g_bad_cfg
		$error("CYC_PER_MS out of range");
	end
	function automatic logic [15:0] sat16(input logic [31:0] v, input logic sgn);
		logic signed [31:0] s;
		s = signed'(v);
		if (sgn) sat16 = (s > `ROF_S16_MAX) ? 16'h7FFF : (s < `ROF_S16_MIN) ? 16'h8000 : v[15:0];
		else sat16 = (s < 0) ? 16'h0000 : (s > `ROF_U16_MAX) ? 16'hFFFF : v[15:0];
	endfunction : sat16

	// ==========================================================
	// millisecond tick
	logic [15:0] tick_cnt_reg, tick_cnt_next;
	logic        ms_tick;
	assign ms_tick = (tick_cnt_reg == 16'(CYC_PER_MS - 1));
	always_comb begin
		tick_cnt_next = ms_tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
	end
	always_ff @(posedge clk_sys) begin
		if (!resetn) tick_cnt_reg <= 16'h0000;
		else tick_cnt_reg <= tick_cnt_next;
	end

	// ==========================================================
	// ready, result pending and save buffer
	logic        ready_reg, ready_next, pend_reg, pend_next;
	logic [31:0] res_pend_reg, res_pend_next;
	logic        busy_reg, busy_next, full_reg, full_next;
	logic        sstart_reg, sstart_next, drop_reg, drop_next;
	logic        ready_rise, save_block, oe_idle, sw_busy;
	assign save_block = save_enable && !save_discard_mode && busy_reg && full_reg;
	assign ready_rise = pend_reg && oe_idle && !sw_busy && !save_block;
	always_comb begin
		res_pend_next = res_pend_reg;
		ready_next    = ready_reg;
		busy_next     = busy_reg;
		full_next     = full_reg;
		sstart_next   = 1'b0;
		drop_next     = 1'b0;
		pend_next     = cycle_done || (pend_reg && !ready_rise);
		if (cycle_done) res_pend_next = result_in;
		if (ready_rise) ready_next = 1'b1;
		else if (cycle_start || sw_busy) ready_next = 1'b0;
		if (busy_reg && save_done) begin
			if (full_reg) begin
				full_next   = 1'b0;
				sstart_next = 1'b1;
			end else begin
				busy_next = 1'b0;
			end
		end
		if (ready_rise && save_enable) begin
			if (!busy_next) begin
				busy_next   = 1'b1;
				sstart_next = 1'b1;
			end else if (!full_next) begin
				full_next = 1'b1;
			end else begin
				drop_next = 1'b1;
			end
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			pend_reg     <= 1'b0;
			res_pend_reg <= 32'h0000_0000;
			ready_reg    <= 1'b0;
			busy_reg     <= 1'b0;
			full_reg     <= 1'b0;
			sstart_reg   <= 1'b0;
			drop_reg     <= 1'b0;
		end else begin
			pend_reg     <= pend_next;
			res_pend_reg <= res_pend_next;
			ready_reg    <= ready_next;
			busy_reg     <= busy_next;
			full_reg     <= full_next;
			sstart_reg   <= sstart_next;
			drop_reg     <= drop_next;
		end
	end

	// ==========================================================
	// parallel output engine
	rof_pkg::rof_out_state_e oe_reg, oe_next;
	logic [7:0]  cnt_reg, cnt_next;
	logic [15:0] out_reg, out_next, hi_reg, hi_next;
	logic        half_reg, half_next, send_reg, send_next;
	logic [7:0]  len_ms;
	assign oe_idle = (oe_reg == rof_pkg::OE_IDLE);
	assign len_ms  = (out_cfg.strobe_len_ms == 8'h00) ? `ROF_STROBE_MIN_MS : out_cfg.strobe_len_ms;
	always_comb begin
		oe_next   = oe_reg;
		cnt_next  = cnt_reg;
		out_next  = out_reg;
		hi_next   = hi_reg;
		half_next = half_reg;
		send_next = ready_rise;
		unique case (oe_reg)
			rof_pkg::OE_IDLE: begin
				if (ready_rise) begin
					cnt_next  = out_cfg.strobe_delay_ms;
					oe_next   = rof_pkg::OE_DELAY;
					half_next = out_cfg.fmt_32bit;
					if (out_cfg.fmt_32bit) begin
						out_next = res_pend_reg[15:0];
						hi_next  = res_pend_reg[31:16];
					end else begin
						out_next = sat16(res_pend_reg, out_cfg.signed_16);
					end
				end
			end
			rof_pkg::OE_DELAY: begin
				if (cnt_reg == 8'h00) begin
					oe_next  = rof_pkg::OE_STROBE;
					cnt_next = len_ms;
				end else if (ms_tick) begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			rof_pkg::OE_STROBE: begin
				if (ms_tick && cnt_reg == 8'h01) begin
					if (half_reg) begin
						half_next = 1'b0;
						out_next  = hi_reg;
						cnt_next  = out_cfg.strobe_delay_ms;
						oe_next   = rof_pkg::OE_DELAY;
					end else begin
						oe_next = rof_pkg::OE_IDLE;
					end
				end else if (ms_tick) begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			oe_reg   <= rof_pkg::OE_IDLE;
			cnt_reg  <= 8'h00;
			out_reg  <= 16'h0000;
			hi_reg   <= 16'h0000;
			half_reg <= 1'b0;
			send_reg <= 1'b0;
		end else begin
			oe_reg   <= oe_next;
			cnt_reg  <= cnt_next;
			out_reg  <= out_next;
			hi_reg   <= hi_next;
			half_reg <= half_next;
			send_reg <= send_next;
		end
	end

	// ==========================================================
	// function switch
	rof_pkg::rof_sw_state_e sw_reg, sw_next;
	logic [15:0] req_cnt_reg, req_cnt_next;
	logic        armed_reg, armed_next, ok_reg, ok_next, fail_reg, fail_next;
	logic        cmdv_reg, cmdv_next, legal, accept;
	rof_pkg::rof_switch_cmd_s cmd_reg, cmd_next;
	assign sw_busy = (sw_reg == rof_pkg::SW_BUSY);
	assign accept  = !sw_busy && armed_reg && switch_request
		&& (req_cnt_reg == 16'(SWREQ_CYC - 1));
	always_comb begin
		unique case (func_select_lines)
			`ROF_FN_PROC_MEM, `ROF_FN_PROC_CARD: legal = (value_in_lines <= `ROF_PROC_MAX);
			`ROF_FN_WINDOW:  legal = (value_in_lines <= `ROF_WINDOW_MAX);
			`ROF_FN_SHUTTER: legal = (value_in_lines[6:4] == 3'h0)
				&& (value_in_lines[3:0] <= `ROF_SHUTTER_MAX);
			`ROF_FN_GAIN, `ROF_FN_BRIGHT: legal = (value_in_lines[6:0] <= `ROF_LEVEL_MAX);
			`ROF_FN_CAPTURE: legal = 1'b1;
			default:         legal = 1'b0;
		endcase
	end
	always_comb begin
		sw_next      = sw_reg;
		req_cnt_next = req_cnt_reg;
		armed_next   = armed_reg;
		ok_next      = ok_reg;
		fail_next    = fail_reg;
		cmd_next     = cmd_reg;
		cmdv_next    = 1'b0;
		if (!switch_request) begin
			req_cnt_next = 16'h0000;
			armed_next   = 1'b1;
		end else if (!sw_busy && armed_reg) begin
			req_cnt_next = req_cnt_reg + 16'h0001;
		end
		if (accept) begin
			armed_next = 1'b0;
			ok_next    = 1'b0;
			if (switch_enable && legal) begin
				sw_next   = rof_pkg::SW_BUSY;
				fail_next = 1'b0;
				cmdv_next = 1'b1;
				cmd_next  = '{code: func_select_lines, value: value_in_lines[6:0],
					camera: value_in_lines[`ROF_CAM_BIT]};
			end else begin
				fail_next = 1'b1;
			end
		end else if (sw_busy && switch_done) begin
			sw_next = rof_pkg::SW_IDLE;
			ok_next = 1'b1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			sw_reg      <= rof_pkg::SW_IDLE;
			req_cnt_reg <= 16'h0000;
			armed_reg   <= 1'b0;
			ok_reg      <= 1'b0;
			fail_reg    <= 1'b0;
			cmd_reg     <= '0;
			cmdv_reg    <= 1'b0;
		end else begin
			sw_reg      <= sw_next;
			req_cnt_reg <= req_cnt_next;
			armed_reg   <= armed_next;
			ok_reg      <= ok_next;
			fail_reg    <= fail_next;
			cmd_reg     <= cmd_next;
			cmdv_reg    <= cmdv_next;
		end
	end

	// ==========================================================
	// outputs
	assign ready            = ready_reg;
	assign send_start       = send_reg;
	assign result_out_lines = out_reg;
	assign result_strobe    = (oe_reg == rof_pkg::OE_STROBE);
	assign save_start       = sstart_reg;
	assign image_dropped    = drop_reg;
	assign save_busy        = busy_reg;
	assign save_buf_full    = full_reg;
	assign switch_ready     = !sw_busy;
	assign switch_ok_flag   = ok_reg;
	assign switch_fail_flag = fail_reg;
	assign switch_cmd       = cmd_reg;
	assign switch_cmd_valid = cmdv_reg;
endmodule : rof_result_switch

// file: test/rof_result_switch_properties.sv
// checker for the result output and function switch block
`timescale 1ns/1ns

module rof_result_switch_properties #(
	parameter int CYC_PER_MS = 4
) (
	input wire logic                     clk_sys,
	input wire logic                     resetn,
	input wire logic                     save_discard_mode,
	input wire logic                     save_done,
	input wire logic                     switch_request,
	input wire logic                     ready,
	input wire logic                     send_start,
	input wire logic [15:0]              result_out_lines,
	input wire logic                     result_strobe,
	input wire logic                     save_start,
	input wire logic                     image_dropped,
	input wire logic                     save_buf_full,
	input wire logic                     switch_ready,
	input wire logic                     switch_ok_flag,
	input wire logic                     switch_fail_flag,
	input wire rof_pkg::rof_switch_cmd_s switch_cmd,
	input wire logic                     switch_cmd_valid
);
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// consecutive cycles with the request held
	logic [15:0] req_cnt_reg;
	always_ff @(posedge clk_sys) begin
		req_cnt_reg <= switch_request ? req_cnt_reg + 16'h0001 : 16'h0000;
	end

	AST_SEND_ON_RISE: assert property (send_start |-> $rose(ready))
		else $error("send pulse without ready rise");
	AST_RISE_SENDS: assert property ($rose(ready) |-> send_start)
		else $error("ready rose without send pulse");
	AST_LINES_HELD: assert property (result_strobe |-> $stable(result_out_lines))
		else $error("result lines moved under strobe");
	AST_BUSY_NO_READY: assert property (!switch_ready && $past(!switch_ready) |-> !ready)
		else $error("ready high while switching");
	AST_CMD_BUSY: assert property (switch_cmd_valid |-> ##[0:1] !switch_ready)
		else $error("switch accepted without busy");
	AST_REQ_HELD: assert property (switch_cmd_valid |-> req_cnt_reg > 16'(CYC_PER_MS))
		else $error("switch accepted on short request");
	AST_CMD_CODE: assert property (switch_cmd_valid |-> switch_cmd.code <= 4'h6)
		else $error("illegal code issued");
	AST_FLAGS_ONE: assert property (!(switch_ok_flag && switch_fail_flag))
		else $error("both switch flags set");
	AST_DROP_DISCARD: assert property (image_dropped |-> save_discard_mode && save_buf_full)
		else $error("image dropped outside discard");
	AST_SAVE_NEXT: assert property (save_done && save_buf_full |-> ##[1:2] save_start)
		else $error("buffered image not started");
endmodule : rof_result_switch_properties

bind rof_result_switch rof_result_switch_properties #(.CYC_PER_MS(CYC_PER_MS))
	rof_result_switch_properties_i (.clk_sys, .resetn, .save_discard_mode, .save_done,
	.switch_request, .ready, .send_start, .result_out_lines, .result_strobe, .save_start,
	.image_dropped, .save_buf_full, .switch_ready, .switch_ok_flag, .switch_fail_flag,
	.switch_cmd, .switch_cmd_valid);

// file: test/rof_plc_model.sv
// far side model: controller issuing switch requests and latching result halves
`timescale 1ns/1ns

module rof_plc_model (
	input  wire logic        clk_sys,
	input  wire logic        go,
	input  wire logic [3:0]  code,
	input  wire logic [7:0]  value,
	input  wire logic        switch_ready,
	input  wire logic        result_strobe,
	input  wire logic [15:0] result_out_lines,
	output logic             switch_request,
	output logic [3:0]       func_select_lines,
	output logic [7:0]       value_in_lines,
	output logic [15:0]      last_half,
	output logic [15:0]      prev_half,
	output logic [7:0]       num_halves
);
	logic strobe_q = 1'b0;
	initial begin
		{switch_request, func_select_lines, value_in_lines} = '0;
		{last_half, prev_half, num_halves} = '0;
	end
	always @(posedge clk_sys) begin
		// request only while switching is open; go is held well past one ms
		switch_request <= go && switch_ready;
		// released lines invert every cycle, so the stale command shows again on every second cycle
		func_select_lines <= go ? code : ~func_select_lines;
		value_in_lines <= go ? value : ~value_in_lines;
		strobe_q <= result_strobe;
		if (result_strobe && !strobe_q) begin
			prev_half <= last_half;
			last_half <= result_out_lines;
			num_halves <= num_halves + 8'h01;
		end
	end
endmodule : rof_plc_model

// file: test/rof_result_switch_test.sv
// testbench: result halves, save buffering and function switching
`timescale 1ns/1ns

module rof_result_switch_test;
	localparam int CYC = 4;
	localparam logic [15:0] SW_TAB [12] = '{16'hC01F, 16'h8120, 16'hC27F, 16'h8280,
		16'hC389, 16'h830A, 16'hC464, 16'hC5E4, 16'h8565, 16'hC6FF, 16'h8700, 16'h0000};
	localparam logic [31:0] SAT_IN [5] = '{32'h0001_0000, 32'hFFFF_0000, 32'hFFFF_FFFF,
		32'h0000_FFFF, 32'hFFFF_FFFE};
	localparam logic [16:0] SAT_EXP [5] = '{17'h1_7FFF, 17'h1_8000, 17'h0_0000, 17'h0_FFFF,
		17'h1_FFFE};
	logic clk_sys = 1'b0, resetn = 1'b0, cycle_start = 1'b0, cycle_done = 1'b0;
	logic save_enable = 1'b0, save_discard_mode = 1'b0, save_done = 1'b0;
	logic switch_enable = 1'b0, switch_done = 1'b0, go = 1'b0, seen_save, seen_drop;
	logic [31:0] result_in = '0;
	logic [3:0] code = '0, func_select_lines;
	logic [7:0] value = '0, value_in_lines, num_halves;
	logic [15:0] result_out_lines, last_half, prev_half;
	logic ready, send_start, result_strobe, save_start, image_dropped, save_busy;
	logic save_buf_full, switch_ready, switch_ok_flag, switch_fail_flag, switch_cmd_valid;
	logic switch_request;
	rof_pkg::rof_out_cfg_s out_cfg = '{1'b0, 1'b1, 8'h01, 8'h01};
	rof_pkg::rof_switch_cmd_s switch_cmd;
	int cycles = 0, checks = 0, num_errors = 0, waited = 0;

	rof_result_switch #(.CYC_PER_MS(CYC)) rof_result_switch_i (.*);
	rof_plc_model rof_plc_model_i (.*);

	// ==========================================
	// helpers
	always #25 clk_sys = ~clk_sys;
	task automatic tick;
		@(posedge clk_sys);
		#1;
	endtask : tick
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_ready(input int lim);
		int k = 0;
		{seen_save, seen_drop} = 2'b00;
		for (waited = 0; waited < lim && k < 3; waited++) begin
			tick;
			k += int'(ready === 1'b1);
			seen_save |= save_start;
			seen_drop |= image_dropped;
		end
	endtask : wait_ready
	task automatic cyc(input logic [31:0] r, input int lim);
		cycle_start <= 1'b1;
		tick;
		cycle_start <= 1'b0;
		cycle_done <= 1'b1;
		result_in <= r;
		tick;
		cycle_done <= 1'b0;
		wait_ready(lim);
	endtask : cyc
	task automatic wait_halves(input logic [7:0] h);
		for (int n = 0; n < 100 && num_halves !== h; n++) tick;
	endtask : wait_halves

	// ==========================================
	// scenarios
	task automatic t_switch;
		logic [15:0] e;
		logic got;
		logic [2:0] fl;
		rof_pkg::rof_switch_cmd_s cmd;
		for (int i = 0; i < 12; i++) begin
			e = SW_TAB[i];
			{switch_enable, code, value, go} <= {e[15], e[11:0], 1'b1};
			got = 1'b0;
			for (int k = 0; k < 3 * CYC; k++) begin
				tick;
				if (switch_cmd_valid === 1'b1) {got, cmd} = {1'b1, switch_cmd};
			end
			go <= 1'b0;
			switch_done <= got;
			tick;
			switch_done <= 1'b0;
			repeat (2) tick;
			fl = {switch_ok_flag, switch_fail_flag, got};
			chk(32'(fl), 32'({e[14], !e[14], e[14]}));
			if (e[14] && e[11:8] < 4'h6)
				chk(32'({cmd.code, cmd.value}), 32'({e[11:8], e[6:0]}));
			if (e[14] && e[11:8] inside {[3:5]}) chk(32'(cmd.camera), 32'(e[7]));
		end
		chk(32'(ready), 32'h0000_0000);
	endtask : t_switch
	task automatic t_out16;
		logic [7:0] h;
		for (int i = 0; i < 5; i++) begin
			h = num_halves;
			out_cfg.signed_16 <= SAT_EXP[i][16];
			cyc(SAT_IN[i], 60);
			chk(32'(waited), 32'h0000_0003);
			wait_halves(h + 8'h01);
			chk(32'(last_half), 32'(SAT_EXP[i][15:0]));
			repeat (6) tick;
		end
	endtask : t_out16
	task automatic t_out32;
		logic [7:0] h0 = num_halves;
		out_cfg.fmt_32bit <= 1'b1;
		cyc(32'h89AB_CDEF, 60);
		cyc(32'h7654_3210, 200);
		chk(32'(num_halves - h0), 32'h0000_0002);
		wait_halves(h0 + 8'h04);
		chk({last_half, prev_half}, 32'h7654_3210);
	endtask : t_out32
	task automatic t_save;
		save_enable <= 1'b1;
		cyc(32'h0000_0001, 60);
		chk(32'({seen_save, save_busy}), 32'h0000_0003);
		cyc(32'h0000_0002, 60);
		chk(32'(save_buf_full), 32'h0000_0001);
		cyc(32'h0000_0003, 60);
		chk(32'(ready), 32'h0000_0000);
		save_done <= 1'b1;
		tick;
		save_done <= 1'b0;
		chk(32'(save_start), 32'h0000_0001);
		wait_ready(60);
		chk(32'({ready, save_buf_full}), 32'h0000_0003);
		save_discard_mode <= 1'b1;
		cyc(32'h0000_0004, 60);
		chk(32'({ready, seen_drop}), 32'h0000_0003);
	endtask : t_save

	// ==========================================
	// run and verdict
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			give_verdict;
		end
	end
	initial begin
		repeat (4) tick;
		resetn <= 1'b1;
		tick;
		t_out16;
		t_switch;
		t_out32;
		t_save;
		give_verdict;
	end
endmodule : rof_result_switch_test
